/* include/wls_pkg.sv */
// What this block does
// - Temperature above warn limit sets flags, alert.
// - Temperature compared is sixteen-sample average.
// - Temperature limit 0FFFh disables; reset 0FFFh.
// - Input above overvoltage limit sets flags, alert.
// - Overvoltage limit resets 0FFFh, which disables.
// - Input below undervoltage limit sets flags, alert.
// - Undervoltage limit resets 0000h, which disables.
// - Limits read and written as words.
// - Flags stick until cause gone and cleared.
// - Status byte bits 6,3,2,1; 7,5,4 zero.
// - Bit 0 flags anything else; resets 1.
// - Word high byte bits 15,13,12,11,9 only.
// - Input undervoltage flags preset, auto-clear once.
// - Output status holds only bit 5.
// - Input status bit layout, bit 3 zero.
// - Undervoltage warn bit presets, clears above lockout.
// - Clear command resets flags and alert.
package wls_pkg;

   localparam logic [7:0]  CODE_CLEAR      = 8'h03;
   localparam logic [7:0]  CODE_OT_WARN    = 8'h51;
   localparam logic [7:0]  CODE_VIN_OV     = 8'h57;
   localparam logic [7:0]  CODE_INPUT_UNDERVOLTAGE_FLAG     = 8'h58;
   localparam logic [7:0]  CODE_STAT_BYTE  = 8'h78;
   localparam logic [7:0]  CODE_STAT_WORD  = 8'h79;
   localparam logic [7:0]  CODE_STAT_VOUT  = 8'h7A;
   localparam logic [7:0]  CODE_STAT_INPUT = 8'h7C;

   localparam int          VAL_W           = 12;
   localparam logic [11:0] LIMIT_OFF_HIGH  = 12'h0FFF;
   localparam logic [11:0] LIMIT_OFF_LOW   = 12'h0000;
   localparam logic [11:0] OT_WARN_RST     = 12'h0FFF;
   localparam logic [11:0] VIN_OV_RST      = 12'h0FFF;
   localparam logic [11:0] INPUT_UNDERVOLTAGE_FLAG_RST      = 12'h0000;

   localparam int          AVG_COUNT       = 16;
   localparam int          AVG_SHIFT       = 4;

   // Sticky flag positions
   localparam int F_OT_WARN     = 0;
   localparam int F_OT_FAULT    = 1;
   localparam int F_VIN_OV_WARN = 2;
   localparam int F_INPUT_UNDERVOLTAGE_FLAG_WARN = 3;
   localparam int F_VIN_OV_FLT  = 4;
   localparam int F_INPUT_UNDERVOLTAGE_FLAG_FLT  = 5;
   localparam int F_IIN_OC_FLT  = 6;
   localparam int F_IIN_OC_WARN = 7;
   localparam int F_INPUT_OVERPOWER_WARNING = 8;
   localparam int F_VOUT_UV     = 9;
   localparam int F_SHORTED     = 10;
   localparam int F_BREAKER     = 11;
   localparam int F_COMM        = 12;
   localparam int F_PG_NEG      = 13;
   localparam int NFLAG         = 14;

   localparam logic [13:0] FLAG_RST    = 14'h2028;
   localparam logic [13:0] UVLO_CLR    = 14'h0028;
   // Power-good negation is preset at reset, so it stays off the alert
   localparam logic [13:0] ALERT_SRC   = 14'h1FFF;

   localparam int SB_OFF   = 6;
   localparam int SB_UV    = 3;
   localparam int SB_TEMP  = 2;
   localparam int SB_CML   = 1;
   localparam int SB_OTHER = 0;
   localparam int SW_VOUT  = 7;
   localparam int SW_INPUT = 5;
   localparam int SW_FET   = 4;
   localparam int SW_PG    = 3;
   localparam int SW_CB    = 1;
   localparam int SV_UV    = 5;

   typedef enum logic [1:0] {
      WLS_SEND_BYTE,
      WLS_WRITE_WORD,
      WLS_READ_BYTE,
      WLS_READ_WORD
   } wls_kind_t;

   typedef struct packed {
      wls_kind_t   kind;
      logic [7:0]  code;
      logic [15:0] wdata;
   } wls_cmd_t;

   typedef struct packed {
      logic fet_off;
      logic power_good;
      logic above_uvlo;
      logic ot_fault;
      logic vin_ov_fault;
      logic input_undervoltage_flag_fault;
      logic input_overcurrent_fault;
      logic iin_oc_warn;
      logic input_overpower_warning;
      logic vout_uv_warn;
      logic shorted_switch;
      logic breaker_trip;
      logic comm_fault;
   } wls_pins_t;

endpackage

/* verilog/wls_avg.sv */
`timescale 1ns/1ps
`default_nettype none
module wls_avg
   import wls_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic              valid_i,
   input  wire logic [VAL_W-1:0]  sample_i,
   output logic                   valid_o,
   output logic      [VAL_W-1:0]  avg_o
);
   logic [VAL_W+AVG_SHIFT-1:0] sum;
   logic [AVG_SHIFT-1:0]       cnt;
   logic [VAL_W+AVG_SHIFT-1:0] next_sum;

   assign next_sum = sum + {{AVG_SHIFT{1'b0}}, sample_i};

   // Sixteen samples per result; at the 1 kHz sample rate this is 16 ms
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sum     <= '0;
         cnt     <= '0;
         valid_o <= 1'b0;
         avg_o   <= '0;
      end else begin
         valid_o <= 1'b0;
         if (valid_i) begin
            cnt <= cnt + 1'b1;
            if (cnt == AVG_SHIFT'(AVG_COUNT - 1)) begin
               avg_o   <= next_sum[VAL_W+AVG_SHIFT-1:AVG_SHIFT];
               valid_o <= 1'b1;
               sum     <= '0;
            end else begin
               sum <= next_sum;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verilog/wls_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wls_top
   import wls_pkg::*;
(
   input  wire logic              CLK_I,
   input  wire logic              NRST_I,
   input  wire logic              CMD_VALID_I,
   input  wire wls_cmd_t          CMD_I,
   input  wire logic              TEMP_VALID_I,
   input  wire logic [VAL_W-1:0]  TEMP_I,
   input  wire logic              VIN_VALID_I,
   input  wire logic [VAL_W-1:0]  VIN_I,
   input  wire wls_pins_t         PINS_I,
   output logic                   RSP_VALID_O,
   output logic      [15:0]       RSP_DATA_O,
   output logic                   RSP_ERR_O,
   output logic                   ALERT_LINE_O,
   output logic                   ALERT_LINE_OE_O
);
   wls_pins_t         pins_meta;
   wls_pins_t         pins;
   logic [VAL_W-1:0]  ot_limit;
   logic [VAL_W-1:0]  ov_limit;
   logic [VAL_W-1:0]  uv_limit;
   logic              avg_valid;
   logic [VAL_W-1:0]  avg_temp;
   logic [VAL_W-1:0]  temp_now;
   logic              temp_seen;
   logic [VAL_W-1:0]  vin_now;
   logic              vin_seen;
   logic              uvlo_seen;
   logic              comm_evt;
   logic              clear_cmd;
   logic              bad_cmd;
   logic [NFLAG-1:0]  flag;
   logic [NFLAG-1:0]  cause;
   logic [NFLAG-1:0]  clr;
   logic              first_uvlo;
   logic              ot_cond;
   logic              ov_cond;
   logic              uv_cond;
   logic [7:0]        stat_byte;
   logic [7:0]        stat_high;
   logic [7:0]        stat_vout;
   logic [7:0]        stat_input;
   logic [15:0]       rd_data;
   logic              next_alert;

   // Pin-level status comes from analog and pin logic in another domain
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pins_meta <= '0;
         pins      <= '0;
      end else begin
         pins_meta <= PINS_I;
         pins      <= pins_meta;
      end
   end

   wls_avg u_avg (
      .clk_i    (CLK_I),
      .nrst_i   (NRST_I),
      .valid_i  (TEMP_VALID_I),
      .sample_i (TEMP_I),
      .valid_o  (avg_valid),
      .avg_o    (avg_temp)
   );

   // Hold the latest averaged temperature and input sample
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         temp_now  <= '0;
         temp_seen <= 1'b0;
         vin_now   <= '0;
         vin_seen  <= 1'b0;
      end else begin
         if (avg_valid) begin
            temp_now  <= avg_temp;
            temp_seen <= 1'b1;
         end
         if (VIN_VALID_I) begin
            vin_now  <= VIN_I;
            vin_seen <= 1'b1;
         end
      end
   end

   // Limit comparisons hold until the measurement moves back
   always_comb begin
      ot_cond = temp_seen && (ot_limit != LIMIT_OFF_HIGH)
                && (temp_now > ot_limit);
      ov_cond = vin_seen && (ov_limit != LIMIT_OFF_HIGH)
                && (vin_now > ov_limit);
      uv_cond = vin_seen && (uv_limit != LIMIT_OFF_LOW)
                && (vin_now < uv_limit);
   end

   // Command decode; commands come from the bus engine on this clock
   always_comb begin
      clear_cmd = 1'b0;
      bad_cmd   = 1'b0;
      if (!CMD_VALID_I) begin
         bad_cmd = 1'b0;
      end else if (CMD_I.code == CODE_CLEAR) begin
         clear_cmd = (CMD_I.kind == WLS_SEND_BYTE);
         bad_cmd   = (CMD_I.kind != WLS_SEND_BYTE);
      end else if (CMD_I.code == CODE_OT_WARN ||
                   CMD_I.code == CODE_VIN_OV ||
                   CMD_I.code == CODE_INPUT_UNDERVOLTAGE_FLAG) begin
         bad_cmd = (CMD_I.kind != WLS_WRITE_WORD) &&
                   (CMD_I.kind != WLS_READ_WORD);
      end else if (CMD_I.code == CODE_STAT_WORD) begin
         bad_cmd = (CMD_I.kind != WLS_READ_WORD);
      end else if (CMD_I.code == CODE_STAT_BYTE ||
                   CMD_I.code == CODE_STAT_VOUT ||
                   CMD_I.code == CODE_STAT_INPUT) begin
         bad_cmd = (CMD_I.kind != WLS_READ_BYTE);
      end else begin
         bad_cmd = 1'b1;
      end
   end

   // Threshold registers keep 12 bits; upper write bits are dropped
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ot_limit <= OT_WARN_RST;
         ov_limit <= VIN_OV_RST;
         uv_limit <= INPUT_UNDERVOLTAGE_FLAG_RST;
      end else if (CMD_VALID_I && !bad_cmd &&
                   CMD_I.kind == WLS_WRITE_WORD) begin
         if (CMD_I.code == CODE_OT_WARN) begin
            ot_limit <= CMD_I.wdata[VAL_W-1:0];
         end else if (CMD_I.code == CODE_VIN_OV) begin
            ov_limit <= CMD_I.wdata[VAL_W-1:0];
         end else if (CMD_I.code == CODE_INPUT_UNDERVOLTAGE_FLAG) begin
            uv_limit <= CMD_I.wdata[VAL_W-1:0];
         end
      end
   end

   // A refused command counts as a communication fault
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         comm_evt <= 1'b0;
      end else begin
         comm_evt <= bad_cmd;
      end
   end

   // First rise above lockout drops the startup undervoltage presets
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         uvlo_seen <= 1'b0;
      end else if (pins.above_uvlo) begin
         uvlo_seen <= 1'b1;
      end
   end

   assign first_uvlo = pins.above_uvlo && !uvlo_seen;

   always_comb begin
      cause                = '0;
      cause[F_OT_WARN]     = ot_cond;
      cause[F_OT_FAULT]    = pins.ot_fault;
      cause[F_VIN_OV_WARN] = ov_cond;
      cause[F_INPUT_UNDERVOLTAGE_FLAG_WARN] = uv_cond;
      cause[F_VIN_OV_FLT]  = pins.vin_ov_fault;
      cause[F_INPUT_UNDERVOLTAGE_FLAG_FLT]  = pins.input_undervoltage_flag_fault;
      cause[F_IIN_OC_FLT]  = pins.input_overcurrent_fault;
      cause[F_IIN_OC_WARN] = pins.iin_oc_warn;
      cause[F_INPUT_OVERPOWER_WARNING] = pins.input_overpower_warning;
      cause[F_VOUT_UV]     = pins.vout_uv_warn;
      cause[F_SHORTED]     = pins.shorted_switch;
      cause[F_BREAKER]     = pins.breaker_trip;
      cause[F_COMM]        = pins.comm_fault || comm_evt;
      cause[F_PG_NEG]      = !pins.power_good;
      clr = ({NFLAG{clear_cmd}}) |
            ({NFLAG{first_uvlo}} & UVLO_CLR);
   end

   // A live cause wins over any clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               flag[gi] <= FLAG_RST[gi];
            end else begin
               flag[gi] <= cause[gi] | (flag[gi] & ~clr[gi]);
            end
         end
      end
   endgenerate

   always_comb begin
      stat_byte           = 8'h00;
      stat_byte[SB_OFF]   = pins.fet_off;
      stat_byte[SB_UV]    = flag[F_INPUT_UNDERVOLTAGE_FLAG_FLT];
      stat_byte[SB_TEMP]  = flag[F_OT_WARN] | flag[F_OT_FAULT];
      stat_byte[SB_CML]   = flag[F_COMM];
      stat_byte[SB_OTHER] = flag[F_VIN_OV_WARN] | flag[F_INPUT_UNDERVOLTAGE_FLAG_WARN]
                          | flag[F_VIN_OV_FLT] | flag[F_IIN_OC_FLT]
                          | flag[F_IIN_OC_WARN] | flag[F_INPUT_OVERPOWER_WARNING]
                          | flag[F_VOUT_UV] | flag[F_SHORTED]
                          | flag[F_BREAKER] | flag[F_PG_NEG];
      stat_vout           = 8'h00;
      stat_vout[SV_UV]    = flag[F_VOUT_UV];
      stat_input = {flag[F_VIN_OV_FLT], flag[F_VIN_OV_WARN],
                    flag[F_INPUT_UNDERVOLTAGE_FLAG_WARN], flag[F_INPUT_UNDERVOLTAGE_FLAG_FLT], 1'b0,
                    flag[F_IIN_OC_FLT], flag[F_IIN_OC_WARN],
                    flag[F_INPUT_OVERPOWER_WARNING]};
      stat_high           = 8'h00;
      stat_high[SW_VOUT]  = flag[F_VOUT_UV];
      stat_high[SW_INPUT] = |stat_input;
      stat_high[SW_FET]   = flag[F_SHORTED];
      stat_high[SW_PG]    = flag[F_PG_NEG];
      stat_high[SW_CB]    = flag[F_BREAKER];
   end

   always_comb begin
      rd_data = 16'h0000;
      if (CMD_I.code == CODE_OT_WARN) begin
         rd_data = {4'h0, ot_limit};
      end else if (CMD_I.code == CODE_VIN_OV) begin
         rd_data = {4'h0, ov_limit};
      end else if (CMD_I.code == CODE_INPUT_UNDERVOLTAGE_FLAG) begin
         rd_data = {4'h0, uv_limit};
      end else if (CMD_I.code == CODE_STAT_BYTE) begin
         rd_data = {8'h00, stat_byte};
      end else if (CMD_I.code == CODE_STAT_WORD) begin
         rd_data = {stat_high, stat_byte};
      end else if (CMD_I.code == CODE_STAT_VOUT) begin
         rd_data = {8'h00, stat_vout};
      end else if (CMD_I.code == CODE_STAT_INPUT) begin
         rd_data = {8'h00, stat_input};
      end
   end

   // Every command gets one answer cycle, refused ones with the error bit
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RSP_VALID_O <= 1'b0;
         RSP_DATA_O  <= 16'h0000;
         RSP_ERR_O   <= 1'b0;
      end else begin
         RSP_VALID_O <= CMD_VALID_I;
         RSP_ERR_O   <= CMD_VALID_I && bad_cmd;
         if (CMD_VALID_I && !bad_cmd && (CMD_I.kind == WLS_READ_WORD ||
                                         CMD_I.kind == WLS_READ_BYTE)) begin
            RSP_DATA_O <= rd_data;
         end else begin
            RSP_DATA_O <= 16'h0000;
         end
      end
   end

   assign next_alert = |(cause & ALERT_SRC) |
                       (ALERT_LINE_OE_O & ~clear_cmd);

   // Open-drain alert: the enable pulls the line low, the level stays 0
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ALERT_LINE_O    <= 1'b0;
         ALERT_LINE_OE_O <= 1'b0;
      end else begin
         ALERT_LINE_O    <= 1'b0;
         ALERT_LINE_OE_O <= next_alert;
      end
   end
endmodule
`default_nettype wire

/* tb/wls_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module wls_properties
   import wls_pkg::*;
(
   input wire logic             CLK_I,
   input wire logic             NRST_I,
   input wire logic             CMD_VALID_I,
   input wire wls_cmd_t         CMD_I,
   input wire logic             TEMP_VALID_I,
   input wire logic [VAL_W-1:0] TEMP_I,
   input wire logic             VIN_VALID_I,
   input wire logic [VAL_W-1:0] VIN_I,
   input wire wls_pins_t        PINS_I,
   input wire logic             RSP_VALID_O,
   input wire logic [15:0]      RSP_DATA_O,
   input wire logic             RSP_ERR_O,
   input wire logic             ALERT_LINE_O,
   input wire logic             ALERT_LINE_OE_O
);
   logic lim;
   logic ok;
   logic [7:0] c;
   assign c = CMD_I.code;
   assign lim = c inside {CODE_OT_WARN, CODE_VIN_OV, CODE_INPUT_UNDERVOLTAGE_FLAG};
   always_comb begin
      case (c)
         CODE_CLEAR: ok = CMD_I.kind == WLS_SEND_BYTE;
         CODE_STAT_WORD: ok = CMD_I.kind == WLS_READ_WORD;
         CODE_STAT_BYTE, CODE_STAT_VOUT,
         CODE_STAT_INPUT: ok = CMD_I.kind == WLS_READ_BYTE;
         default: ok = lim && CMD_I.kind != WLS_SEND_BYTE
                       && CMD_I.kind != WLS_READ_BYTE;
      endcase
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   a_rsp_latency: assert property (CMD_VALID_I |=> RSP_VALID_O)
      else $error("no answer one cycle after command");
   a_rsp_cause: assert property (RSP_VALID_O |-> $past(CMD_VALID_I))
      else $error("answer without command");
   a_refuse_bad: assert property (CMD_VALID_I && !ok |=>
      RSP_ERR_O && RSP_DATA_O == 16'h0000) else $error("bad command taken");
   a_accept_good: assert property (CMD_VALID_I && ok |=> !RSP_ERR_O)
      else $error("legal command refused");
   a_limit_upper: assert property (CMD_VALID_I && lim |=>
      RSP_DATA_O[15:12] == 4'h0) else $error("limit upper bits set");
   a_byte_fixed: assert property (CMD_VALID_I && c == CODE_STAT_BYTE |=>
      (RSP_DATA_O & 16'hffb0) == 16'h0000) else $error("status byte fixed bits");
   a_word_fixed: assert property (CMD_VALID_I && c == CODE_STAT_WORD |=>
      (RSP_DATA_O & 16'h45b0) == 16'h0000) else $error("status word fixed bits");
   a_vout_only: assert property (CMD_VALID_I && c == CODE_STAT_VOUT |=>
      (RSP_DATA_O & 16'hffdf) == 16'h0000) else $error("output status bits");
   a_input_gap: assert property (CMD_VALID_I && c == CODE_STAT_INPUT |=>
      (RSP_DATA_O & 16'hff08) == 16'h0000) else $error("input status bits");
   a_alert_hold: assert property ($fell(ALERT_LINE_OE_O) |->
      $past(CMD_VALID_I && c == CODE_CLEAR && CMD_I.kind == WLS_SEND_BYTE))
      else $error("alert dropped");
   c_refused: cover property (CMD_VALID_I && !ok);
   c_alert_up: cover property ($rose(ALERT_LINE_OE_O));
   c_alert_drop: cover property ($fell(ALERT_LINE_OE_O));
endmodule
bind wls_top wls_properties chk_u (
   .CLK_I, .NRST_I, .CMD_VALID_I, .CMD_I, .TEMP_VALID_I, .TEMP_I,
   .VIN_VALID_I, .VIN_I, .PINS_I, .RSP_VALID_O, .RSP_DATA_O, .RSP_ERR_O,
   .ALERT_LINE_O, .ALERT_LINE_OE_O
);
`default_nettype wire

/* tb/wls_host.sv */
`timescale 1ns/1ps
`default_nettype none
module wls_host
   import wls_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rsp_valid_i,
   input  wire logic [15:0] rsp_data_i,
   input  wire logic        rsp_err_i,
   output logic             cmd_valid_o,
   output wls_cmd_t         cmd_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   // Answer is taken one edge after the strobe; a late answer reads as x
   task automatic xfer(input wls_kind_t k, input logic [7:0] c,
                       input logic [15:0] w, output logic [15:0] d,
                       output logic e);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_o <= '{k, c, w};
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_o <= ~cmd_o;
      #1;
      d = rsp_valid_i ? rsp_data_i : 16'hxxxx;
      e = rsp_valid_i ? rsp_err_i : 1'bx;
   endtask
endmodule
`default_nettype wire

/* tb/test_wls_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_wls_top;
   import wls_pkg::*;
   logic        clk, nrst, tv, vv, cv, rv, re, ao, aoe, e;
   logic [11:0] temp, vin;
   logic [15:0] rdat, d;
   wls_pins_t   pins;
   wls_cmd_t    cmd;
   int          n_errors, n_tests, flg, al, vs, ta, hv, ht, tn;
   int          cyc = 0;
   int          lim[3];
   logic [7:0]  cs[7] = '{CODE_OT_WARN, CODE_VIN_OV, CODE_INPUT_UNDERVOLTAGE_FLAG,
      CODE_STAT_BYTE, CODE_STAT_WORD, CODE_STAT_VOUT, CODE_STAT_INPUT};
   wls_top dut_u (
      .CLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(cv), .CMD_I(cmd),
      .TEMP_VALID_I(tv), .TEMP_I(temp), .VIN_VALID_I(vv), .VIN_I(vin),
      .PINS_I(pins), .RSP_VALID_O(rv), .RSP_DATA_O(rdat), .RSP_ERR_O(re),
      .ALERT_LINE_O(ao), .ALERT_LINE_OE_O(aoe));
   wls_host host_u (.clk_i(clk), .rsp_valid_i(rv), .rsp_data_i(rdat),
      .rsp_err_i(re), .cmd_valid_o(cv), .cmd_o(cmd));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic int live();
      return int'(ht != 0 && lim[0] != 12'hfff && ta > lim[0])
         | int'(hv != 0 && lim[1] != 12'hfff && vs > lim[1]) << 1
         | int'(hv != 0 && lim[2] != 0 && vs < lim[2]) << 2
         | int'({pins.breaker_trip, pins.shorted_switch,
                 pins.vout_uv_warn}) << 5;
   endfunction
   function automatic logic [15:0] exp_rd(input logic [7:0] c);
      logic [7:0] inp, sb;
      inp = {1'b0, flg[1], flg[2], flg[3], 4'h0};
      // Bit 0 stays set since power good is held negated in this run
      sb = {1'b0, pins.fet_off, 2'b0, flg[3], flg[0], flg[4], 1'b1};
      case (c)
         CODE_OT_WARN: return 16'(lim[0]);
         CODE_VIN_OV: return 16'(lim[1]);
         CODE_INPUT_UNDERVOLTAGE_FLAG: return 16'(lim[2]);
         CODE_STAT_BYTE: return {8'h00, sb};
         CODE_STAT_WORD: return {flg[5], 1'b0, |inp, flg[6], 2'b10,
                                 flg[7], 1'b0, sb};
         CODE_STAT_VOUT: return 16'(flg[5]) << 5;
         default: return {8'h00, inp};
      endcase
   endfunction
   task automatic chk(input string n, input logic [15:0] x,
                      input logic [15:0] s);
      n_tests++;
      if (s !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic rdall();
      for (int i = 0; i < 7; i++) begin
         host_u.xfer(i inside {0, 1, 2, 4} ? WLS_READ_WORD : WLS_READ_BYTE,
                     cs[i], 16'h0000, d, e);
         chk("read", exp_rd(cs[i]), d);
         chk("read err", 16'h0000, 16'(e));
      end
   endtask
   task automatic wr(input int i, input logic [15:0] w);
      host_u.xfer(WLS_WRITE_WORD, cs[i], w, d, e);
      lim[i] = int'(w[11:0]);
      chk("write", 16'h0000, d);
      chk("write err", 16'h0000, 16'(e));
   endtask
   task automatic bad(input wls_kind_t k, input logic [7:0] c);
      host_u.xfer(k, c, 16'hffff, d, e);
      chk("refused data", 16'h0000, d);
      chk("refused err", 16'h0001, 16'(e));
      flg |= 16;
      al = 1;
   endtask
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
      flg |= live();
      al |= int'(live() != 0);
      chk("alert", 16'(al), 16'(aoe));
      chk("alert level", 16'h0000, 16'(ao));
   endtask
   task automatic clr();
      host_u.xfer(WLS_SEND_BYTE, CODE_CLEAR, 16'h0000, d, e);
      chk("clear", 16'h0000, d | 16'(e));
      flg = live();
      al = int'(live() != 0);
      settle();
   endtask
   task automatic vsamp(input int v);
      @(posedge clk);
      vv <= 1'b1;
      vin <= 12'(v);
      @(posedge clk);
      vv <= 1'b0;
      vin <= ~12'(v);
      vs = v;
      hv = 1;
      settle();
   endtask
   task automatic tsamp(input int n);
      repeat (n) begin
         @(posedge clk);
         tv <= 1'b1;
         temp <= 12'h800;
         @(posedge clk);
         tv <= 1'b0;
         temp <= 12'h7ff;
      end
      tn += n;
      ht = int'(tn >= 16);
      ta = 'h800;
      settle();
   endtask
   task automatic mreset();
      pins <= '0;
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      lim = '{4095, 4095, 0};
      flg = 12;
      {al, hv, ht, tn} = '0;
   endtask
   task automatic close_out();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      {nrst, tv, vv, temp, vin, pins, n_errors, n_tests} = '0;
      void'($urandom(32'hbaf2));
      mreset();
      rdall();
      settle();
      for (int i = 0; i < 3; i++) begin
         wr(i, 16'($urandom));
      end
      rdall();
      bad(WLS_READ_WORD, 8'h52);
      bad(WLS_READ_WORD, CODE_STAT_BYTE);
      bad(WLS_WRITE_WORD, CODE_STAT_WORD);
      bad(WLS_SEND_BYTE, CODE_VIN_OV);
      settle();
      {pins.fet_off, pins.above_uvlo} <= 2'b11;
      flg &= ~12;
      settle();
      rdall();
      clr();
      rdall();
      wr(0, 16'h07fe);
      wr(1, 16'h0800);
      wr(2, 16'h0400);
      vsamp('h800);
      rdall();
      vsamp('h801);
      rdall();
      vsamp('h500);
      rdall();
      clr();
      vsamp('h3ff);
      rdall();
      wr(2, 16'h0000);
      settle();
      clr();
      wr(1, 16'h0ffe);
      vsamp('hfff);
      rdall();
      wr(1, 16'h0fff);
      settle();
      clr();
      tsamp(15);
      rdall();
      tsamp(1);
      rdall();
      wr(0, 16'h0fff);
      settle();
      clr();
      rdall();
      {pins.vout_uv_warn, pins.shorted_switch, pins.breaker_trip} <= 3'b111;
      settle();
      rdall();
      {pins.vout_uv_warn, pins.shorted_switch, pins.breaker_trip} <= 3'b000;
      settle();
      clr();
      rdall();
      mreset();
      rdall();
      close_out();
   end
endmodule
`default_nettype wire
